// *** logic/ccp_device.sv ***
// Channel processor: scan sequencing, filtering, reference, re-tune, watchdog
// Notes on behaviour
// R1 - Three power modes, two settable scan rates
// R2 - Host sets reduced rate slower than full
// R3 - Wake mode scans one channel, others slower
// R4 - Counts fall as capacitance rises; drive outputs
// R5 - Over-limit count is stopped, reads as maximum
// R6 - Touch found comparing count with reference
// R7 - Reference drifts slowly, frozen during touch
// R8 - Reseed bit copies latest counts to references
// R9 - Re-tune when reference leaves boundary, if enabled
// R10 - Default boundary target/16, strictly beyond triggers
// R11 - Status bit shows briefly after re-tune
// R12 - Tuning error: comp zero, comp>=1023, or range
// R13 - Error flag updated only when tuning completes
// R14 - Re-tune suppressed for error timeout after error
// R15 - Step down power mode after idle timeout
// R16 - IIR filter damping is beta over 256
// R17 - Reset flag set on reset, cleared by ack
// R18 - Software reset command resets device
// R19 - Watchdog on slow timer, restarted each pass
// R20 - Watchdog expiry forces full cold reset; code keeps channel counts, references and touch bits
// R21 - Defaults loaded at power-up without host
// R22 - Watchdog period is 1024 ms
// R23 - Compensation held unsigned, ten bits wide
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module ccp_device #(
  parameter int NCH = 20, // Channels
  parameter int LF_DIV_P = ccp_pkg::LF_DIV, // Cycles per slow tick
  parameter int WDT_TICKS_P = ccp_pkg::WDT_TICKS // Watchdog length, slow ticks
) (
  input wire logic pclk,
  input wire logic presetn,
  ccp_link_if.dev link,
  output logic conv_start,
  output logic [4:0] conv_chan,
  input wire logic conv_done,
  input wire logic [ccp_pkg::DW-1:0] conv_count,
  input wire logic conv_over,
  output logic tune_start,
  input wire logic tune_done,
  input wire logic [ccp_pkg::COMP_W-1:0] tune_comp,
  input wire logic [ccp_pkg::DW-1:0] tune_count,
  output logic [NCH-1:0] touch,
  output ccp_pkg::ccp_pmode_t power_mode,
  output logic tune_err,
  output logic retune_evt
);
  import ccp_pkg::*;
  if (NCH < 1 || NCH > 32 || LF_DIV_P < 2 || WDT_TICKS_P < 2) begin : g_bad
    $error("ccp_device: parameter out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic core_rst_q; // Soft or watchdog reset pulse
  logic ack_q; // Link answer
  logic [DW-1:0] rdata_q; // Link read data
  logic reset_flag_q; // Reset indication
  logic [DW-1:0] maxc_q, beta_q, target_q, bound_q, np_q, lp_q, ulpdiv_q;
  logic [DW-1:0] modeto_q, errto_q, thresh_q, flags_q; // Configuration
  logic wr, rd; // Link access this cycle
  logic [DW-1:0] raw_q [NCH]; // Latest clamped counts
  logic [DW-1:0] filt_q [NCH]; // Filtered counts
  logic [DW-1:0] lta_q [NCH]; // Long-term references
  logic [15:0] lf_cnt_q; // Slow tick divider
  logic lf_tick; // One-cycle slow tick
  logic [31:0] wdt_q; // Watchdog count
  ccp_state_t st_q; // Sequencer state
  logic [4:0] ch_q, last_q; // Current and last channel of pass
  logic [DW-1:0] iv_q; // Scan interval count
  logic [DW-1:0] div_q; // Wake-mode pass divider
  logic [DW-1:0] idle_q; // Ticks with no touch
  logic [DW-1:0] errt_q; // Error suppression count
  ccp_pmode_t mode_q; // Power mode
  logic retune_q, terr_q; // Status bits
  logic [DW-1:0] clamped, bnd; // Clamped count, boundary
  logic [24:0] mix; // Filter sum
  logic [DW-1:0] fnew; // New filtered count
  logic tch, lta_oor, retune_go, pass_go, tune_bad;
  logic [NCH-1:0] touch_q; // Per-channel touch

  assign wr = link.req && link.we && !ack_q;
  assign rd = link.req && !link.we && !ack_q;
  assign lf_tick = (lf_cnt_q == 16'(LF_DIV_P - 1));
  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign link.reset_flag = reset_flag_q;
  assign touch = touch_q;
  assign power_mode = mode_q;
  assign tune_err = terr_q;
  assign retune_evt = retune_q;
  assign conv_chan = ch_q;
  logic conv_start_q, tune_start_q; // Front-end pulses
  assign conv_start = conv_start_q;
  assign tune_start = tune_start_q;

  // Boundary check: strictly outside target +/- bound
  function automatic logic oor(input logic [DW-1:0] v, input logic [DW-1:0] t,
                               input logic [DW-1:0] b);
    oor = ({1'b0, v} > ({1'b0, t} + {1'b0, b})) || ({1'b0, v} + {1'b0, b} < {1'b0, t});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Measurement datapath
  always_comb begin
    clamped = (conv_over || conv_count >= maxc_q) ? maxc_q : conv_count; // R5
    mix = 25'({1'b0, beta_q[7:0]}) * 25'(filt_q[ch_q]) +
          25'(9'h100 - {1'b0, beta_q[7:0]}) * 25'(clamped); // R16
    fnew = mix[23:8];
    tch = (lta_q[ch_q] > fnew) && ((lta_q[ch_q] - fnew) > thresh_q); // R4 R6
    bnd = (bound_q == 16'h0000) ? {4'h0, target_q[15:4]} : bound_q; // R10
    lta_oor = oor(lta_q[ch_q], target_q, bnd); // R9 R10
    retune_go = flags_q[FL_RETUNE_EN] && lta_oor && (errt_q == 16'h0000); // R9 R14
    pass_go = (st_q == S_IDLE) && lf_tick &&
              (iv_q >= ((mode_q == PM_FULL) ? np_q : lp_q)); // R1
    tune_bad = (tune_comp == '0) || (tune_comp >= COMP_MAX) || // R12 R23
               oor(tune_count, target_q, bnd);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core reset from command or watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rst_q <= 1'b0;
    end else begin
      core_rst_q <= (wr && link.addr == A_CTRL && link.wdata[CTRL_SOFT_RST]) || // R18
                    (lf_tick && wdt_q >= 32'(WDT_TICKS_P - 1)); // R20 R22
    end
  end

  // Slow tick divider and watchdog, restarted while the loop idles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_cnt_q <= '0;
      wdt_q <= '0;
    end else if (core_rst_q) begin
      lf_cnt_q <= '0;
      wdt_q <= '0;
    end else begin
      lf_cnt_q <= lf_tick ? 16'h0000 : lf_cnt_q + 16'h0001;
      if (st_q == S_IDLE) begin
        wdt_q <= '0; // R19
      end else if (lf_tick) begin
        wdt_q <= wdt_q + 32'h1; // R19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link answer and configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= wr || rd;
      if (rd) begin
        if (link.addr >= A_COUNT && link.addr < A_COUNT + 8'(NCH)) begin
          rdata_q <= filt_q[5'(link.addr - A_COUNT)];
        end else if (link.addr >= A_LTA && link.addr < A_LTA + 8'(NCH)) begin
          rdata_q <= lta_q[5'(link.addr - A_LTA)];
        end else begin
          unique case (link.addr)
            A_STATUS: rdata_q <= {11'h0, mode_q, retune_q, terr_q, reset_flag_q};
            A_TOUCH_LO: rdata_q <= 16'(32'(touch_q));
            A_TOUCH_HI: rdata_q <= 16'(32'(touch_q) >> 16);
            A_MAXC: rdata_q <= maxc_q;
            A_BETA: rdata_q <= beta_q;
            A_TARGET: rdata_q <= target_q;
            A_BOUND: rdata_q <= bound_q;
            A_NP_RATE: rdata_q <= np_q;
            A_LP_RATE: rdata_q <= lp_q;
            A_ULP_DIV: rdata_q <= ulpdiv_q;
            A_MODE_TO: rdata_q <= modeto_q;
            A_ERR_TO: rdata_q <= errto_q;
            A_THRESH: rdata_q <= thresh_q;
            A_FLAGS: rdata_q <= flags_q;
            default: rdata_q <= '0; // Unmapped reads zero
          endcase
        end
      end
    end
  end

  // Settings return to programmed defaults on every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn || core_rst_q) begin // R21
      {maxc_q, beta_q, target_q, bound_q} <= {DEF_MAXC, DEF_BETA, DEF_TARGET, DEF_BOUND};
      {np_q, lp_q, ulpdiv_q, modeto_q} <= {DEF_NP_RATE, DEF_LP_RATE, DEF_ULP_DIV, DEF_MODE_TO};
      {errto_q, thresh_q, flags_q} <= {DEF_ERR_TO, DEF_THRESH, DEF_FLAGS};
    end else if (wr) begin
      unique case (link.addr)
        A_MAXC: maxc_q <= link.wdata;
        A_BETA: beta_q <= {8'h00, link.wdata[7:0]};
        A_TARGET: target_q <= link.wdata;
        A_BOUND: bound_q <= link.wdata;
        A_NP_RATE: np_q <= link.wdata; // R1
        A_LP_RATE: lp_q <= link.wdata; // R1
        A_ULP_DIV: ulpdiv_q <= link.wdata;
        A_MODE_TO: modeto_q <= link.wdata;
        A_ERR_TO: errto_q <= link.wdata;
        A_THRESH: thresh_q <= link.wdata;
        A_FLAGS: flags_q <= {14'h0, link.wdata[1:0]};
        default: ;
      endcase
    end
  end

  // Reset indication: set by any reset, set wins over acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_flag_q <= 1'b1; // R17
    end else if (core_rst_q) begin
      reset_flag_q <= 1'b1; // R17
    end else if (wr && link.addr == A_CTRL && link.wdata[CTRL_ACK_RST]) begin
      reset_flag_q <= 1'b0; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn || core_rst_q) begin
      st_q <= S_IDLE;
      ch_q <= '0;
      last_q <= '0;
      iv_q <= '0;
      div_q <= '0;
      conv_start_q <= 1'b0;
      tune_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      tune_start_q <= 1'b0;
      if (st_q == S_IDLE && lf_tick) begin
        iv_q <= pass_go ? 16'h0000 : iv_q + 16'h0001;
      end
      unique case (st_q)
        S_IDLE: begin
          if (pass_go) begin
            // Wake mode: channel 0 every pass, all only every Nth pass
            last_q <= (mode_q != PM_MIN || div_q == 16'h0000) ? 5'(NCH - 1) : 5'h0; // R3
            div_q <= (div_q + 16'h0001 >= ulpdiv_q) ? 16'h0000 : div_q + 16'h0001; // R3
            ch_q <= '0;
            conv_start_q <= 1'b1;
            st_q <= S_CONV;
          end
        end
        S_CONV: begin
          if (conv_done && retune_go) begin
            tune_start_q <= 1'b1; // R9
            st_q <= S_TUNE;
          end else if (conv_done) begin
            st_q <= (ch_q == last_q) ? S_IDLE : S_CONV;
            conv_start_q <= (ch_q != last_q);
            ch_q <= (ch_q == last_q) ? ch_q : ch_q + 5'h1;
          end
        end
        S_TUNE: begin
          if (tune_done) begin
            st_q <= (ch_q == last_q) ? S_IDLE : S_CONV;
            conv_start_q <= (ch_q != last_q);
            ch_q <= (ch_q == last_q) ? ch_q : ch_q + 5'h1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Per-channel counts, filter and reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        raw_q[i] <= '0;
        filt_q[i] <= '0;
        lta_q[i] <= '0;
      end
      touch_q <= '0;
    end else begin
      if (st_q == S_CONV && conv_done) begin
        raw_q[ch_q] <= clamped; // R5
        filt_q[ch_q] <= fnew; // R16
        touch_q[ch_q] <= tch; // R6
        if (!tch && lta_q[ch_q] < fnew) begin
          lta_q[ch_q] <= lta_q[ch_q] + 16'h0001; // R7
        end else if (!tch && lta_q[ch_q] > fnew) begin
          lta_q[ch_q] <= lta_q[ch_q] - 16'h0001; // R7
        end
      end else if (st_q == S_TUNE && tune_done) begin
        lta_q[ch_q] <= tune_count; // Fresh reference after tuning
        filt_q[ch_q] <= tune_count;
      end
      if (wr && link.addr == A_CTRL && link.wdata[CTRL_RESEED]) begin
        for (int i = 0; i < NCH; i++) begin
          lta_q[i] <= raw_q[i]; // R8
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tuning status, error timeout and power mode stepping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn || core_rst_q) begin
      terr_q <= 1'b0;
      retune_q <= 1'b0;
      errt_q <= '0;
      mode_q <= PM_FULL;
      idle_q <= '0;
    end else begin
      if (pass_go) begin
        retune_q <= 1'b0; // R11
      end
      if (st_q == S_CONV && conv_done && retune_go) begin
        retune_q <= 1'b1; // R11
      end
      if (st_q == S_TUNE && tune_done) begin
        terr_q <= tune_bad; // R12 R13
        errt_q <= tune_bad ? errto_q : errt_q; // R14
      end else if (lf_tick && errt_q != 16'h0000) begin
        errt_q <= errt_q - 16'h0001; // R14
      end
      if (|touch_q) begin
        mode_q <= PM_FULL;
        idle_q <= '0;
      end else if (lf_tick && flags_q[FL_STEP_EN] && idle_q >= modeto_q) begin
        mode_q <= (mode_q == PM_FULL) ? PM_REDUCED : PM_MIN; // R15
        idle_q <= '0;
      end else if (lf_tick && idle_q != 16'hffff) begin
        idle_q <= idle_q + 16'h0001; // R15
      end
    end
  end
endmodule

// *** logic/ccp_host.sv ***
// Host controller: APB register front end driving the device link
`timescale 1ns/1ps
module ccp_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  ccp_link_if.host link
);
  import ccp_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic rdy_q; // Second access cycle marker
  logic [31:0] prdata_q; // Read data register
  logic apb_wr; // Write takes effect
  logic [AW-1:0] addr_q; // Software address
  logic [DW-1:0] wdata_q; // Software write data
  logic [DW-1:0] rdata_q; // Last read result
  ccp_hstate_t st_q; // Link state
  logic req_q, we_q; // Link request
  logic [AW-1:0] laddr_q; // Link address
  logic [DW-1:0] lwdata_q; // Link write data
  logic flag_prev_q, seen_q; // Reset flag edge and sticky
  logic go; // Accepted start

  assign apb_wr = psel && penable && rdy_q && pwrite;
  assign go = apb_wr && paddr == H_GO && st_q == HS_IDLE_ST && (|pwdata[4:0]);
  assign pready = rdy_q;
  assign prdata = prdata_q;
  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = laddr_q;
  assign link.wdata = lwdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, read data from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      rdy_q <= psel && penable && !rdy_q;
      if (psel && penable && !rdy_q) begin
        unique case (paddr)
          H_ADDR: prdata_q <= 32'(addr_q);
          H_WDATA: prdata_q <= 32'(wdata_q);
          H_STAT: prdata_q <= {29'h0, seen_q, link.reset_flag, st_q != HS_IDLE_ST};
          H_RDATA: prdata_q <= 32'(rdata_q);
          default: prdata_q <= '0; // Unmapped and GO read zero
        endcase
      end
    end
  end

  // Software address and data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
      wdata_q <= '0;
    end else if (apb_wr && paddr == H_ADDR) begin
      addr_q <= pwdata[AW-1:0];
    end else if (apb_wr && paddr == H_WDATA) begin
      wdata_q <= pwdata[DW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer; command bits become a write to the control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= HS_IDLE_ST;
      req_q <= 1'b0;
      we_q <= 1'b0;
      laddr_q <= '0;
      lwdata_q <= '0;
      rdata_q <= '0;
    end else begin
      unique case (st_q)
        HS_IDLE_ST: begin
          if (go) begin
            req_q <= 1'b1;
            st_q <= HS_REQ_ST;
            if (pwdata[GO_RD]) begin
              we_q <= 1'b0;
              laddr_q <= addr_q;
            end else if (pwdata[GO_WR]) begin
              we_q <= 1'b1;
              laddr_q <= addr_q;
              lwdata_q <= wdata_q;
            end else begin
              we_q <= 1'b1;
              laddr_q <= A_CTRL;
              lwdata_q <= '0;
              lwdata_q[CTRL_ACK_RST] <= pwdata[GO_ACK]; // R17
              lwdata_q[CTRL_SOFT_RST] <= pwdata[GO_SRST]; // R18
              lwdata_q[CTRL_RESEED] <= pwdata[GO_RESEED]; // R8
            end
          end
        end
        HS_REQ_ST: begin
          if (link.ack) begin
            req_q <= 1'b0;
            st_q <= HS_IDLE_ST;
            rdata_q <= we_q ? rdata_q : link.rdata;
          end
        end
        default: st_q <= HS_IDLE_ST;
      endcase
    end
  end

  // New device reset seen: rising flag sets, write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_prev_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      flag_prev_q <= link.reset_flag;
      if (link.reset_flag && !flag_prev_q) begin
        seen_q <= 1'b1; // R17
      end else if (apb_wr && paddr == H_STAT && pwdata[HS_SEEN]) begin
        seen_q <= 1'b0;
      end
    end
  end
endmodule

// *** logic/ccp_link_if.sv ***
// Register link between host controller and channel processor
`timescale 1ns/1ps
interface ccp_link_if;
  logic req; // Request, held until ack
  logic we; // Write when high
  logic [ccp_pkg::AW-1:0] addr; // Register address
  logic [ccp_pkg::DW-1:0] wdata; // Write data
  logic ack; // One-cycle answer
  logic [ccp_pkg::DW-1:0] rdata; // Read data, valid with ack
  logic reset_flag; // Live reset indication level
  modport dev(input req, we, addr, wdata, output ack, rdata, reset_flag);
  modport host(output req, we, addr, wdata, input ack, rdata, reset_flag);
endinterface

// *** logic/ccp_pkg.sv ***
// Shared constants and types for the capacitive channel processor pair
package ccp_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Clocking and timing
  localparam int CLK_HZ = 25000000; // System clock rate
  localparam int LF_HZ = 10000; // Always-on slow oscillator rate
  localparam int LF_DIV = CLK_HZ / LF_HZ; // System cycles per slow tick
  localparam int WDT_MS = 1024; // Watchdog period in ms
  localparam int WDT_TICKS = WDT_MS * (LF_HZ / 1000); // Watchdog in slow ticks
  ////////////////////////////////////////////////////////////////////////////
  // Link widths
  localparam int AW = 8; // Device register address width
  localparam int DW = 16; // Device register data width
  localparam int COMP_W = 10; // Tuning compensation width
  localparam logic [COMP_W-1:0] COMP_MAX = 10'h3ff; // Top compensation value
  ////////////////////////////////////////////////////////////////////////////
  // Device register addresses
  localparam logic [AW-1:0] A_STATUS = 8'h10; // Status word
  localparam logic [AW-1:0] A_TOUCH_LO = 8'h11; // Touch bits 15..0
  localparam logic [AW-1:0] A_TOUCH_HI = 8'h12; // Touch bits 31..16
  localparam logic [AW-1:0] A_COUNT = 8'h20; // Filtered count, channel 0
  localparam logic [AW-1:0] A_LTA = 8'h40; // Long-term reference, channel 0
  localparam logic [AW-1:0] A_MAXC = 8'h80; // Maximum count limit
  localparam logic [AW-1:0] A_BETA = 8'h81; // Filter beta, low byte
  localparam logic [AW-1:0] A_TARGET = 8'h82; // Tuning target
  localparam logic [AW-1:0] A_BOUND = 8'h83; // Re-tune boundary, 0 = target/16
  localparam logic [AW-1:0] A_NP_RATE = 8'h84; // Full-rate scan interval, ticks
  localparam logic [AW-1:0] A_LP_RATE = 8'h85; // Reduced-rate scan interval, ticks
  localparam logic [AW-1:0] A_ULP_DIV = 8'h86; // Passes per full pass in wake mode
  localparam logic [AW-1:0] A_MODE_TO = 8'h87; // Mode timeout, ticks
  localparam logic [AW-1:0] A_ERR_TO = 8'h88; // Tuning error timeout, ticks
  localparam logic [AW-1:0] A_THRESH = 8'h89; // Touch threshold
  localparam logic [AW-1:0] A_FLAGS = 8'h8a; // Enables
  localparam logic [AW-1:0] A_CTRL = 8'hd0; // Command bits
  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_ACK_RST = 0; // Acknowledge reset flag
  localparam int CTRL_SOFT_RST = 1; // Software reset
  localparam int CTRL_RESEED = 3; // Reseed references
  localparam int ST_RESET = 0; // Reset seen
  localparam int ST_TERR = 1; // Tuning error
  localparam int ST_RETUNE = 2; // Re-tune just ran
  localparam int ST_MODE = 3; // Power mode, two bits
  localparam int FL_RETUNE_EN = 0; // Automatic re-tune enable
  localparam int FL_STEP_EN = 1; // Mode stepping enable
  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [DW-1:0] DEF_MAXC = 16'h3fff;
  localparam logic [DW-1:0] DEF_BETA = 16'h00c0;
  localparam logic [DW-1:0] DEF_TARGET = 16'h0320;
  localparam logic [DW-1:0] DEF_BOUND = 16'h0000;
  localparam logic [DW-1:0] DEF_NP_RATE = 16'h0064;
  localparam logic [DW-1:0] DEF_LP_RATE = 16'h01f4;
  localparam logic [DW-1:0] DEF_ULP_DIV = 16'h0004;
  localparam logic [DW-1:0] DEF_MODE_TO = 16'h4e20;
  localparam logic [DW-1:0] DEF_ERR_TO = 16'h2710;
  localparam logic [DW-1:0] DEF_THRESH = 16'h0010;
  localparam logic [DW-1:0] DEF_FLAGS = 16'h0003;
  ////////////////////////////////////////////////////////////////////////////
  // Host APB register offsets and go bits
  localparam logic [7:0] H_ADDR = 8'h00; // Device address
  localparam logic [7:0] H_WDATA = 8'h04; // Device write data
  localparam logic [7:0] H_GO = 8'h08; // Start a transfer
  localparam logic [7:0] H_STAT = 8'h0c; // Host status
  localparam logic [7:0] H_RDATA = 8'h10; // Last read data
  localparam int GO_RD = 0, GO_WR = 1, GO_ACK = 2, GO_SRST = 3, GO_RESEED = 4;
  localparam int HS_BUSY = 0, HS_DEVRST = 1, HS_SEEN = 2;
  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {PM_FULL = 2'h0, PM_REDUCED = 2'h1, PM_MIN = 2'h2} ccp_pmode_t;
  typedef enum logic [2:0] {S_IDLE = 3'h1, S_CONV = 3'h2, S_TUNE = 3'h4} ccp_state_t;
  typedef enum logic [1:0] {HS_IDLE_ST = 2'h1, HS_REQ_ST = 2'h2} ccp_hstate_t;
endpackage

// *** testbench/ccp_bench.sv ***
// Bench joining host and device over the link
`timescale 1ns/1ps
module capacitive_channel_processing_bench;
  import ccp_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, conv_start, tune_start, tune_err, conv_done = 1'h0, tune_done = 1'h0;
  logic conv_over = 1'h0; // Front end overflow flag
  ccp_pmode_t power_mode;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  ccp_link_if lk();
  ccp_host i_ccp_host(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .link(lk));
  ccp_device #(.LF_DIV_P(4), .WDT_TICKS_P(64)) i_ccp_device(.pclk(pclk),
    .presetn(presetn), .link(lk), .conv_start(conv_start), .conv_chan(),
    .conv_done(conv_done), .conv_count(16'h0320), .conv_over(conv_over),
    .tune_start(tune_start), .tune_done(tune_done), .tune_comp(10'h100),
    .tune_count(16'h0320), .touch(), .power_mode(power_mode), .tune_err(tune_err),
    .retune_evt());
  ccp_link_props i_ccp_link_props(.pclk(pclk), .presetn(presetn), .req(lk.req),
    .we(lk.we), .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .rdata(lk.rdata),
    .reset_flag(lk.reset_flag));
  always #20 pclk = ~pclk;
  // Front end answers each start one cycle later
  always @(posedge pclk) begin
    conv_done <= conv_start;
    tune_done <= tune_start;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic dev(input logic [7:0] a, input logic [15:0] d, input logic [4:0] go);
    apb(1'h1, H_ADDR, {24'h0, a});
    apb(1'h1, H_WDATA, {16'h0, d});
    apb(1'h1, H_GO, {27'h0, go});
    repeat (20) begin
      apb(1'h0, H_STAT, 32'h0);
      if (rd[HS_BUSY] === 1'h0) break;
    end
    apb(1'h0, H_RDATA, 32'h0);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, H_STAT, 32'h0);
    chk("stat", rd, 32'h6);
    dev(A_MAXC, 16'h0, 5'h1);
    chk("maxc", rd, {16'h0, DEF_MAXC});
    dev(A_THRESH, 16'h0020, 5'h2);
    dev(A_THRESH, 16'h0, 5'h1);
    chk("thresh", rd, 32'h20);
    dev(A_CTRL, 16'h0, 5'h4);
    apb(1'h1, H_STAT, 32'h4);
    apb(1'h0, H_STAT, 32'h0);
    chk("ack", rd, 32'h0);
    $display("test reset flag done");
    dev(A_CTRL, 16'h0, 5'h8);
    repeat (5) @(posedge pclk);
    apb(1'h0, H_STAT, 32'h0);
    chk("srst", rd, 32'h6);
    dev(A_THRESH, 16'h0, 5'h1);
    chk("dflt", rd, {16'h0, DEF_THRESH});
    $display("test soft reset done");
    repeat (3000) @(posedge pclk);
    dev(A_COUNT, 16'h0, 5'h1);
    chk("count", rd, 32'h320);
    dev(A_LTA, 16'h0, 5'h1);
    chk("ref", rd, 32'h320);
    chk("terr", {31'h0, tune_err}, 32'h0);
    chk("mode", {30'h0, power_mode}, 32'h0);
    $display("test processing done");
    dev(A_LP_RATE, 16'h03e8, 5'h2);
    dev(A_MAXC, 16'h0300, 5'h2);
    conv_over <= 1'h1;
    repeat (8000) @(posedge pclk);
    dev(A_COUNT, 16'h0, 5'h1);
    chk("clamp", rd, 32'h300);
    dev(A_TOUCH_LO, 16'h0, 5'h1);
    chk("touch", rd, 32'hffff);
    dev(A_CTRL, 16'h0, 5'h10);
    dev(A_LTA, 16'h0, 5'h1);
    chk("reseed", rd, 32'h300);
    $display("test clamp and reseed done");
    close_out();
  end
endmodule

// *** testbench/ccp_link_props.sv ***
// Link protocol checker for the channel processor pair
`timescale 1ns/1ps
module ccp_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic we,
  input wire logic [ccp_pkg::AW-1:0] addr,
  input wire logic [ccp_pkg::DW-1:0] wdata,
  input wire logic ack,
  input wire logic [ccp_pkg::DW-1:0] rdata,
  input wire logic reset_flag
);
  import ccp_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctl = we && addr == A_CTRL;
  property p_ack_next; req && !ack |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_pulse; ack |=> !ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_drop; ack |=> !req; endproperty
  a_drop: assert property (p_drop) else $error("req held");
  property p_quiet; !req |=> !ack; endproperty
  a_quiet: assert property (p_quiet) else $error("stray ack");
  property p_hold; req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_rdata; $changed(rdata) |-> ack && !we || $rose(reset_flag); endproperty
  a_rdata: assert property (p_rdata) else $error("rdata moved");
  property p_clr; ack && ctl && wdata == 16'h0001 |-> ##[0:2] !reset_flag; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_srst; ack && ctl && wdata[CTRL_SOFT_RST] |-> ##[1:3] reset_flag; endproperty
  a_srst: assert property (p_srst) else $error("no soft reset");
  property p_fell; $fell(reset_flag) |-> $past(ctl && wdata[CTRL_ACK_RST]); endproperty
  a_fell: assert property (p_fell) else $error("flag lost");
endmodule
